/* src/gpm_pkg.sv */
package gpm_pkg;

  localparam int NPORT  = 3;
  localparam int PIN_W  = 8;
  localparam int MODE_W = 2;
  localparam int CON_W  = PIN_W * MODE_W;
  localparam int NIRQ   = 8;

  typedef logic [MODE_W-1:0] gpm_mode_t;
  typedef logic [NPORT-1:0][PIN_W-1:0] gpm_bits_t;
  typedef logic [NPORT-1:0][CON_W-1:0] gpm_con_t;

  // Function-select codes
  localparam gpm_mode_t MODE_00 = 2'h0;
  localparam gpm_mode_t MODE_01 = 2'h1;
  localparam gpm_mode_t MODE_10 = 2'h2;
  localparam gpm_mode_t MODE_11 = 2'h3;

  // Pins that physically exist on each port
  localparam gpm_bits_t PIN_PRESENT = {8'h1f, 8'hff, 8'hff};

  // Per pin, bit m set means function-select code m gives plain GPIO.
  // Codes with no listed function also fall back to GPIO.
  localparam logic [NPORT-1:0][PIN_W-1:0][3:0] GPIO_MODES = {
    {4'hf, 4'hf, 4'hf, 4'he, 4'he, 4'hf, 4'h1, 4'h5},
    {4'h9, 4'h9, 4'h9, 4'h1, 4'h5, 4'h5, 4'h5, 4'h9},
    {4'h2, 4'hd, 4'hd, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1}};

  // Pin whose code 00 is the power-on-reset indicator output
  localparam gpm_bits_t POR_PIN = {8'h00, 8'h00, 8'h80};
  localparam int        POR_PORT_IDX = 0;
  localparam int        POR_BIT_IDX  = 7;

  // External interrupt line i is fed by pin IRQ_PIN[i] of port IRQ_PORT[i]
  localparam logic [NIRQ-1:0][1:0] IRQ_PORT = {
    2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
  localparam logic [NIRQ-1:0][2:0] IRQ_PIN = {
    3'h7, 3'h6, 3'h5, 3'h1, 3'h0, 3'h6, 3'h5, 3'h3};

  // Reset values
  localparam logic [PIN_W-1:0] OUT_RST     = 8'h00;
  localparam gpm_bits_t        PAD_OE_RST  = {8'h00, 8'h00, 8'h80};
  localparam gpm_bits_t        PAD_O_RST   = {8'h00, 8'h00, 8'h00};
  localparam gpm_bits_t        PAD_PU_RST  = {8'h00, 8'h00, 8'h00};
  localparam gpm_bits_t        BITS_RST    = {8'h00, 8'h00, 8'h00};
  localparam logic [NIRQ-1:0]  IRQ_RST     = 8'h00;
  localparam logic             POR_PIN_RST = 1'b0;
  localparam logic             POR_PIN_IDLE = 1'b1;

endpackage

/* src/gpm_ctl_if.sv */
interface gpm_ctl_if #(
  parameter int W = 8
) ();
  logic         wr_out;
  logic         wr_set;
  logic         wr_clr;
  logic         wr_tgl;
  logic [W-1:0] wdata;
  logic [W-1:0] value;

  modport ctl (
    output wr_out,
    output wr_set,
    output wr_clr,
    output wr_tgl,
    output wdata,
    input  value
  );

  modport store (
    input  wr_out,
    input  wr_set,
    input  wr_clr,
    input  wr_tgl,
    input  wdata,
    output value
  );
endinterface

/* src/gpm_sync.sv */
module gpm_sync #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import gpm_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } gpm_sync_state_t;

  gpm_sync_state_t st;
  gpm_sync_state_t next_st;

  always_comb
  begin
    next_st      = st;
    next_st.meta = d;
    next_st.q    = st.meta;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign q = st.q;
endmodule

/* src/gpm_outval.sv */
module gpm_outval #(
  parameter logic [7:0] RST_VAL = gpm_pkg::OUT_RST
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  gpm_ctl_if.store  bus
);
  import gpm_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0] value;
  } gpm_outval_state_t;

  gpm_outval_state_t st;
  gpm_outval_state_t next_st;

  // Writes in one cycle apply in order: load, set, clear, toggle
  always_comb
  begin
    next_st = st;
    if (bus.wr_out)
    begin
      next_st.value = bus.wdata;
    end
    if (bus.wr_set)
    begin
      next_st.value = next_st.value | bus.wdata;
    end
    if (bus.wr_clr)
    begin
      next_st.value = next_st.value & ~bus.wdata;
    end
    if (bus.wr_tgl)
    begin
      next_st.value = next_st.value ^ bus.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.value <= RST_VAL;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign bus.value = st.value;
endmodule

/* src/gpm_top.sv */
// Overview of operation
// - Per-pin pull-up enable bit for input pins
// - Output or open-circuit enable forces pull-up off
// - Pins reset as inputs except port 0 pin 7; sampled levels readable
// - Open-circuit plus output blocks input and interrupt
// - No interrupts from open-drain driven pins
// - Output pins follow output-value register bits
// - Set write raises bits written as one
// - Clear write lowers bits written as one
// - Toggle write inverts bits written as one
// - Output enable low leaves pin undriven
// - Push-pull mode drives zero or one
// - Open-drain with value zero pulls low
// - Open-drain with value one floats pin
// - Two-bit function field per pin, 00 GPIO except port 0 pin 7 and port 2 pins 3,4
// - Port 0 interrupt pins, functions, reset output
// - Port 1 interrupt pins and PWM functions
// - Port 2 functions; pin 2 GPIO only
// - Port 2 pins 3,4 default to debug
// - Reset output low only on power-on reset
module gpm_top (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               por_rst_n,
  input  wire gpm_pkg::gpm_con_t  pin_function_select_reg,
  input  wire gpm_pkg::gpm_bits_t output_drive_enable_bits,
  input  wire gpm_pkg::gpm_bits_t open_circuit_enable_bits,
  input  wire gpm_pkg::gpm_bits_t pull_up_enable_bits,
  input  wire gpm_pkg::gpm_bits_t sw_wdata,
  input  wire logic [2:0]         output_value_wr,
  input  wire logic [2:0]         output_set_strobe_wr,
  input  wire logic [2:0]         output_clear_strobe_wr,
  input  wire logic [2:0]         output_toggle_strobe_wr,
  input  wire gpm_pkg::gpm_bits_t alt_o,
  input  wire gpm_pkg::gpm_bits_t alt_oe,
  input  wire gpm_pkg::gpm_bits_t pad_i,
  output gpm_pkg::gpm_bits_t      pad_o,
  output gpm_pkg::gpm_bits_t      pad_oe,
  output gpm_pkg::gpm_bits_t      pad_pu_en,
  output gpm_pkg::gpm_bits_t      alt_i,
  output gpm_pkg::gpm_bits_t      pin_level_input_reg,
  output gpm_pkg::gpm_bits_t      output_value_reg,
  output logic [7:0]              ext_interrupt_line
);
  import gpm_pkg::*;

  typedef struct packed {
    gpm_bits_t       pad_o;
    gpm_bits_t       pad_oe;
    gpm_bits_t       pad_pu;
    gpm_bits_t       level;
    gpm_bits_t       alt_i;
    logic [NIRQ-1:0] irq;
  } gpm_top_state_t;

  gpm_top_state_t st;
  gpm_top_state_t next_st;
  gpm_bits_t      pin_sync;
  gpm_bits_t      out_val;
  gpm_bits_t      in_ok;
  gpm_bits_t      irq_src;
  logic           por_pin;
  logic           next_por_pin;

  ////////////////////////////////////////////////////////////////////////////
  // Pin level synchroniser

  gpm_sync #(
    .W (NPORT * PIN_W)
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (pad_i),
    .q     (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output-value registers, one per port

  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    gpm_ctl_if #(.W(PIN_W)) ctl ();

    assign ctl.wr_out = output_value_wr[p];
    assign ctl.wr_set = output_set_strobe_wr[p];
    assign ctl.wr_clr = output_clear_strobe_wr[p];
    assign ctl.wr_tgl = output_toggle_strobe_wr[p];
    assign ctl.wdata  = sw_wdata[p];
    assign out_val[p] = ctl.value;

    gpm_outval #(
      .RST_VAL (OUT_RST)
    ) u_outval (
      .mclk  (mclk),
      .rst_n (rst_n),
      .bus   (ctl.store)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad control, input path and interrupt feed

  always_comb
  begin
    gpm_mode_t mode;
    logic      oen;
    logic      oce;
    logic      ov;
    mode    = MODE_00;
    oen     = 1'b0;
    oce     = 1'b0;
    ov      = 1'b0;
    next_st = st;
    in_ok   = BITS_RST;
    irq_src = BITS_RST;
    for (int p = 0; p < NPORT; p++)
    begin
      for (int b = 0; b < PIN_W; b++)
      begin
        mode = gpm_mode_t'(pin_function_select_reg[p][2*b +: 2]);
        oen  = output_drive_enable_bits[p][b];
        oce  = open_circuit_enable_bits[p][b];
        ov   = out_val[p][b];
        in_ok[p][b]   = ~(oce & oen);
        irq_src[p][b] = in_ok[p][b] & (mode == MODE_00);
        if (!PIN_PRESENT[p][b])
        begin
          next_st.pad_o[p][b]  = 1'b0;
          next_st.pad_oe[p][b] = 1'b0;
          next_st.pad_pu[p][b] = 1'b0;
        end
        else if (GPIO_MODES[p][b][mode])
        begin
          // Open-drain drives only a low; push-pull drives the value
          next_st.pad_o[p][b]  = ov & ~oce;
          next_st.pad_oe[p][b] = oen & ~(oce & ov);
          next_st.pad_pu[p][b] = pull_up_enable_bits[p][b]
                                 & ~oen & ~oce;
        end
        else if (POR_PIN[p][b] && mode == MODE_00)
        begin
          next_st.pad_o[p][b]  = POR_PIN_IDLE;
          next_st.pad_oe[p][b] = 1'b1;
          next_st.pad_pu[p][b] = 1'b0;
        end
        else
        begin
          // Peripheral owns the pad, including the debug pins at code 00
          next_st.pad_o[p][b]  = alt_o[p][b];
          next_st.pad_oe[p][b] = alt_oe[p][b];
          next_st.pad_pu[p][b] = pull_up_enable_bits[p][b]
                                 & ~alt_oe[p][b] & ~oce;
        end
        next_st.level[p][b] = pin_sync[p][b] & in_ok[p][b];
        next_st.alt_i[p][b] = pin_sync[p][b];
      end
    end
    for (int i = 0; i < NIRQ; i++)
    begin
      next_st.irq[i] = pin_sync[IRQ_PORT[i]][IRQ_PIN[i]]
                       & irq_src[IRQ_PORT[i]][IRQ_PIN[i]];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.pad_o  <= PAD_O_RST;
      st.pad_oe <= PAD_OE_RST;
      st.pad_pu <= PAD_PU_RST;
      st.level  <= BITS_RST;
      st.alt_i  <= BITS_RST;
      st.irq    <= IRQ_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-on-reset indicator pin, cleared only by the power-on reset

  always_comb
  begin
    next_por_pin = next_st.pad_o[POR_PORT_IDX][POR_BIT_IDX];
  end

  always_ff @(posedge mclk or negedge por_rst_n)
  begin
    if (!por_rst_n)
    begin
      por_pin <= POR_PIN_RST;
    end
    else
    begin
      por_pin <= next_por_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb
  begin
    pad_o = st.pad_o;
    pad_o[POR_PORT_IDX][POR_BIT_IDX] = por_pin;
  end

  assign pad_oe              = st.pad_oe;
  assign pad_pu_en           = st.pad_pu;
  assign alt_i               = st.alt_i;
  assign pin_level_input_reg = st.level;
  assign output_value_reg    = out_val;
  assign ext_interrupt_line  = st.irq;
endmodule

/* test/gpm_assertions.sv */
module gpm_assertions (
  input wire logic                mclk,
  input wire logic                rst_n,
  input wire logic                por_rst_n,
  input wire gpm_pkg::gpm_con_t   pin_function_select_reg,
  input wire gpm_pkg::gpm_bits_t  output_drive_enable_bits,
  input wire gpm_pkg::gpm_bits_t  open_circuit_enable_bits,
  input wire gpm_pkg::gpm_bits_t  pull_up_enable_bits,
  input wire gpm_pkg::gpm_bits_t  sw_wdata,
  input wire logic [2:0]          output_value_wr,
  input wire logic [2:0]          output_set_strobe_wr,
  input wire logic [2:0]          output_clear_strobe_wr,
  input wire logic [2:0]          output_toggle_strobe_wr,
  input wire gpm_pkg::gpm_bits_t  pad_i,
  input wire gpm_pkg::gpm_bits_t  pad_o,
  input wire gpm_pkg::gpm_bits_t  pad_oe,
  input wire gpm_pkg::gpm_bits_t  pad_pu_en,
  input wire gpm_pkg::gpm_bits_t  pin_level_input_reg,
  input wire gpm_pkg::gpm_bits_t  output_value_reg,
  input wire logic [7:0]          ext_interrupt_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] oe, oc, v, w, blk;
  logic [3:0] age, ns;
  logic       g1;
  assign oe = output_drive_enable_bits[1];
  assign oc = open_circuit_enable_bits[1];
  assign v = output_value_reg[1];
  assign w = sw_wdata[1];
  assign blk = oe & oc;
  assign g1 = pin_function_select_reg[1] == 16'h0;
  assign ns = {output_value_wr[1], output_set_strobe_wr[1],
               output_clear_strobe_wr[1], output_toggle_strobe_wr[1]};
  // Edges since reset release, so history never reaches into reset
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      age <= 4'h0;
    else
      age <= {age[2:0], 1'b1};
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_quiet;
    (age[2] && $stable(blk) && g1)[*4];
  endsequence
  chk_drive_enable: assert property (
    age[0] && $past(g1) |-> pad_oe[1] == $past(oe & ~(oc & v)))
    else $error("pad_oe differs from enable and mode");
  chk_pull_gate: assert property (
    age[0] && $past(g1) |-> pad_pu_en[1] == $past(pull_up_enable_bits[1] & ~oe & ~oc))
    else $error("pull-up not gated");
  chk_level_sync: assert property (
    s_quiet |-> pin_level_input_reg[1] == ($past(pad_i[1], 3) & ~blk))
    else $error("pin level wrong");
  chk_irq_map: assert property (
    s_quiet |-> ext_interrupt_line[7:3] ==
      ({$past(pad_i[1][7:5], 3), $past(pad_i[1][1:0], 3)} & ~{blk[7:5], blk[1:0]}))
    else $error("interrupt line wrong");
  chk_set_bits: assert property (
    ns == 4'h4 |=> v == $past(v | w))
    else $error("set strobe wrong");
  chk_clear_bits: assert property (
    ns == 4'h2 |=> v == $past(v & ~w))
    else $error("clear strobe wrong");
  chk_toggle_bits: assert property (
    ns == 4'h1 |=> v == $past(v ^ w))
    else $error("toggle strobe wrong");
  // Only the power-on reset may pull the indicator low, so system reset must not mask this
  chk_por_high: assert property (
    disable iff (!por_rst_n)
    (por_rst_n && pin_function_select_reg[0][15:14] == 2'h0)[*2] |-> pad_o[0][7])
    else $error("reset indicator low");
endmodule

bind gpm_top gpm_assertions i_chk (.*);

/* test/gpm_pins.sv */
module gpm_pins (
  input wire logic               mclk,
  input wire gpm_pkg::gpm_bits_t pad_o,
  input wire gpm_pkg::gpm_bits_t pad_oe,
  input wire gpm_pkg::gpm_bits_t pad_pu_en,
  input wire gpm_pkg::gpm_bits_t ext_o,
  input wire gpm_pkg::gpm_bits_t ext_en,
  output gpm_pkg::gpm_bits_t     pad_i
);
  timeunit 1ns;
  timeprecision 1ns;
  gpm_pkg::gpm_bits_t flt = '0;
  // Undriven pins without pull-up wander so a stale level never passes
  always @(negedge mclk)
    flt <= ~flt;
  assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_en & ext_o)
               | (~pad_oe & ~ext_en & (pad_pu_en | flt));
endmodule

/* test/gpm_top_tb.sv */
module gpm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gpm_pkg::*;
  logic mclk = 1'b0;
  logic rst_n, por_rst_n;
  gpm_con_t fs;
  gpm_bits_t oe, oc, pu, wd, ao, aoe, xo, xe, pi, po, poe, ppu, ai, lvl, val;
  logic [2:0] wv, ws, wc, wt;
  logic [7:0] irq;
  int err_count, comparisons;
  always #50 mclk = ~mclk;
  gpm_top i_dut (
    .mclk(mclk),
    .rst_n(rst_n),
    .por_rst_n(por_rst_n),
    .pin_function_select_reg(fs),
    .output_drive_enable_bits(oe),
    .open_circuit_enable_bits(oc),
    .pull_up_enable_bits(pu),
    .sw_wdata(wd),
    .output_value_wr(wv),
    .output_set_strobe_wr(ws),
    .output_clear_strobe_wr(wc),
    .output_toggle_strobe_wr(wt),
    .alt_o(ao),
    .alt_oe(aoe),
    .pad_i(pi),
    .pad_o(po),
    .pad_oe(poe),
    .pad_pu_en(ppu),
    .alt_i(ai),
    .pin_level_input_reg(lvl),
    .output_value_reg(val),
    .ext_interrupt_line(irq)
  );
  gpm_pins i_pins (
    .mclk(mclk),
    .pad_o(po),
    .pad_oe(poe),
    .pad_pu_en(ppu),
    .ext_o(xo),
    .ext_en(xe),
    .pad_i(pi)
  );
  ////////////////////////////////////////////////////////////////
  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk);
    #10;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    comparisons++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Port 1 write; k selects load, set, clear, toggle
  task automatic wr(int k, logic [7:0] d);
    wd[1] = d;
    {wv[1], ws[1], wc[1], wt[1]} = 4'h8 >> k;
    tick();
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    #1000000;
    err_count++;
    conclude();
  end
  initial
  begin
    {fs, oe, oc, pu, wd, ao, aoe, xo, xe} = '0;
    {wv, ws, wc, wt} = '0;
    {rst_n, por_rst_n, err_count, comparisons} = '0;
    tick(10);
    chk("oe p0", 8'h80, poe[0]);
    chk("pu p1", 8'h00, ppu[1]);
    {rst_n, por_rst_n} = 2'b11;
    tick();
    chk("por pin", 8'h01, po[0][7]);
    wr(0, 8'h3c);
    chk("load", 8'h3c, val[1]);
    wr(1, 8'h05);
    chk("set", 8'h3d, val[1]);
    wr(2, 8'h0c);
    chk("clear", 8'h31, val[1]);
    wr(3, 8'hf0);
    chk("toggle", 8'hc1, val[1]);
    {wv, ws, wc, wt} = '0;
    {oe[1], oc[1], pu[1]} = {8'hd3, 8'h51, 8'hff};
    tick();
    chk("drive en", 8'h92, poe[1]);
    chk("drive lvl", 8'h80, po[1] & poe[1]);
    chk("pull-up", 8'h2c, ppu[1]);
    tick(3);
    chk("level", 8'hac, lvl[1]);
    chk("irq p1", 8'h14, {3'h0, irq[7:3]});
    {oe[1], oc[1], xe[1], xo[1], xe[0], xo[0]} = {16'h0, 16'hff23, 16'hff68};
    tick(4);
    chk("ext level", 8'h23, lvl[1]);
    chk("alt in", 8'h23, ai[1]);
    chk("irq all", 8'h3f, irq);
    xo[1] = 8'hdc;
    tick(2);
    chk("sync hold", 8'h23, lvl[1]);
    tick();
    chk("sync new", 8'hdc, lvl[1]);
    fs[0][7:6] = 2'h1;
    tick(4);
    chk("irq mode", 8'hc6, irq);
    {xe, oe[1], oe[2]} = {24'h0, 8'h04, 8'h04};
    for (int m = 0; m < 4; m++)
    begin
      {fs[1][5:4], fs[2][5:4]} = {2{m[1:0]}};
      tick();
      chk("p1.2 code", {7'h0, GPIO_MODES[1][2][m]}, poe[1][2]);
      chk("p2.2 code", 8'h01, poe[2][2]);
    end
    {wd[2], ws[2]} = {8'h04, 1'b1};
    tick();
    ws[2] = 1'b0;
    chk("p2 set", 8'h04, val[2]);
    tick();
    chk("p2 drive", 8'h04, po[2] & poe[2]);
    {fs[2], aoe[2], ao[2]} = {16'h0, 8'h18, 8'h08};
    tick();
    chk("debug oe", 8'h18, poe[2] & 8'h18);
    chk("debug o", 8'h08, po[2] & 8'h18);
    rst_n = 1'b0;
    tick(2);
    chk("warm por", 8'h01, po[0][7]);
    chk("warm oe", 8'h00, poe[2]);
    por_rst_n = 1'b0;
    tick();
    chk("cold por", 8'h00, po[0][7]);
    {rst_n, por_rst_n} = 2'b11;
    tick(2);
    chk("por back", 8'h01, po[0][7]);
    conclude();
  end
endmodule
